// File: src/fcsd_host.v
// Host controller that issues flash command sequences over the NOR bus pins.
// Assumes the flash pins are synchronous to mclk_i; one op at a time.
//
// Summary of operation
// [RULE1] Device abandons malformed sequences, back to read
// [RULE2] Suspend only in erase; resume only suspended
// [RULE3] Address latched on later falling strobe edge
// [RULE4] Data latched on first rising strobe edge
// [RULE5] Single F0 write returns to read mode
// [RULE6] Identifier entry: AA, 55, 90 unlock sequence
// [RULE7] Device identifier read over three offsets
// [RULE8] Offset 03/06 reports secured region lock
// [RULE9] Sector plus 02/04 reports sector protection
// [RULE10] Program: two unlocks, A0, location and value
// [RULE11] Buffered: unlocks, 25 at sector, count
// [RULE12] All buffer locations in one page
// [RULE13] Buffered sequence at most 21/37 cycles
// [RULE14] After abort: unlocks then F0 command
// [RULE15] Erase: six writes, 30 sector, 10 chip
// [RULE16] Sector chosen only by A21-A12
// [RULE17] Unlock/command addresses otherwise ignored
// [RULE18] Read mode reads need no commands
// [RULE19] Suspended erase allows reads, programs, identifier
// [RULE20] Query 98 only from read or identifier
// [RULE21] Device returns to read after power-up
// [RULE22] Suspended erasing sector reads give status
// [RULE23] Secured region: 88 enter; 90 then 00 exit
// [RULE24] After loads, 29 at sector starts programming
// [RULE25] Reset honoured between cycles, not during operation
`include "fcsd_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module fcsd_host #(
  parameter AW = 22,
  parameter DW = 16,
  parameter CLK_NS = `FCSD_CLK_NS
) (
  input wire mclk_i,
  input wire rst_i,
  input wire req_i,
  input wire [3:0] op_i,
  input wire byte_mode_i,
  input wire [AW-1:0] addr_i,
  input wire [DW-1:0] data_i,
  input wire [5:0] count_m1_i,
  input wire load_we_i,
  input wire [5:0] load_idx_i,
  input wire [AW-1:0] load_addr_i,
  input wire [DW-1:0] load_data_i,
  output reg busy_o,
  output reg done_o,
  output reg err_o,
  output reg [DW-1:0] rdata_o,
  output reg [AW-1:0] flash_a_o,
  output reg [DW-1:0] flash_dq_o,
  output reg flash_dq_oe_o,
  input wire [DW-1:0] flash_dq_i,
  output reg flash_ce_n_o,
  output reg flash_we_n_o,
  output reg flash_oe_n_o
);
  localparam [7:0] T_SETUP = (`FCSD_T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam [7:0] T_PULSE = (`FCSD_T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam [7:0] T_HOLD = (`FCSD_T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_SETUP = 6'h02;
  localparam [5:0] S_PULSE = 6'h04;
  localparam [5:0] S_HOLD = 6'h08;
  localparam [5:0] S_NEXT = 6'h10;
  localparam [5:0] S_FETCH = 6'h20;
  reg [5:0] state_r;
  reg [7:0] tmr_r;
  reg [5:0] step_r;
  reg [5:0] last_r;
  reg [3:0] op_r;
  reg bm_r;
  reg is_read_r;
  reg [AW-1:0] addr_r;
  reg [DW-1:0] data_r;
  reg [5:0] cnt_r;
  reg [5:0] bidx_r;
  reg fetched_r;
  reg cyc_read;
  reg [AW-1:0] cyc_a;
  reg [DW-1:0] cyc_d;
  wire [DW-1:0] buf_data;
  wire [AW-1:0] buf_addr;
  wire [AW+DW-1:0] buf_rd;
  assign buf_addr = buf_rd[AW+DW-1:DW];
  assign buf_data = buf_rd[DW-1:0];
  fcsd_buf_mem #(.AW(6), .DW(AW+DW)) fcsd_buf_mem_inst (
    .mclk_i(mclk_i),
    .we_i(load_we_i),
    .waddr_i(load_idx_i),
    .wdata_i({load_addr_i, load_data_i}),
    .raddr_i(bidx_r),
    .rdata_o(buf_rd)
  );
  // Unlock/command addresses only need the low 12 bits; upper bits sent as zero
  function [AW-1:0] cmd_addr;
    input bm;
    input [1:0] kind;
    begin
      if (kind == 2'd0)
        cmd_addr = {{(AW-12){1'b0}}, bm ? `FCSD_ADDR_CMD_BYTE : `FCSD_ADDR_CMD_WORD};
      else if (kind == 2'd1)
        cmd_addr = {{(AW-12){1'b0}}, bm ? `FCSD_ADDR_UNL_BYTE : `FCSD_ADDR_UNL_WORD};
      else
        cmd_addr = {{(AW-12){1'b0}}, bm ? `FCSD_ADDR_QRY_BYTE : `FCSD_ADDR_QRY_WORD};
    end
  endfunction
  // Sector select keeps A21-A12 only, low bits zero
  function [AW-1:0] sect;
    input [AW-1:0] a;
    begin
      sect = {a[AW-1:12], 12'h000}; // [RULE16]
    end
  endfunction
  function [DW-1:0] cb;
    input [7:0] c;
    begin
      cb = {{(DW-8){1'b0}}, c};
    end
  endfunction
  // Cycle table per operation and step
  always @*
  begin
    cyc_read = 1'b0;
    cyc_a = {AW{1'b0}};
    cyc_d = {DW{1'b0}};
    if (step_r == 6'd0 && op_r != `FCSD_OP_READ && op_r != `FCSD_OP_RESET &&
        op_r != `FCSD_OP_SUSPEND && op_r != `FCSD_OP_RESUME && op_r != `FCSD_OP_QUERY &&
        op_r != `FCSD_OP_ID_READ)
    begin
      cyc_a = cmd_addr(bm_r, 2'd0);
      cyc_d = cb(`FCSD_CMD_UNLOCK1); // [RULE17]
    end
    else if (step_r == 6'd1 && op_r != `FCSD_OP_ID_READ)
    begin
      cyc_a = cmd_addr(bm_r, 2'd1);
      cyc_d = cb(`FCSD_CMD_UNLOCK2);
    end
    else
    begin
      case (op_r)
        `FCSD_OP_READ, `FCSD_OP_ID_READ:
        begin
          cyc_read = 1'b1; // [RULE18] [RULE7] [RULE8] [RULE9] [RULE22]
          cyc_a = addr_r;
        end
        `FCSD_OP_RESET:
        begin
          cyc_a = addr_r;
          cyc_d = cb(`FCSD_CMD_RESET); // [RULE5] [RULE25]
        end
        `FCSD_OP_SUSPEND:
        begin
          cyc_a = addr_r;
          cyc_d = cb(`FCSD_CMD_SUSPEND); // [RULE2]
        end
        `FCSD_OP_RESUME:
        begin
          cyc_a = addr_r;
          cyc_d = cb(`FCSD_CMD_RESUME); // [RULE2] [RULE19]
        end
        `FCSD_OP_QUERY:
        begin
          cyc_a = cmd_addr(bm_r, 2'd2);
          cyc_d = cb(`FCSD_CMD_QUERY); // [RULE20]
        end
        `FCSD_OP_AUTOSEL:
        begin
          cyc_a = cmd_addr(bm_r, 2'd0);
          cyc_d = cb(`FCSD_CMD_AUTOSEL); // [RULE6]
        end
        `FCSD_OP_SEC_ENTER:
        begin
          cyc_a = cmd_addr(bm_r, 2'd0);
          cyc_d = cb(`FCSD_CMD_SEC_ENTER); // [RULE23]
        end
        `FCSD_OP_SEC_EXIT:
        begin
          cyc_a = (step_r == 6'd2) ? cmd_addr(bm_r, 2'd0) : addr_r;
          cyc_d = (step_r == 6'd2) ? cb(`FCSD_CMD_AUTOSEL) : cb(`FCSD_CMD_SEC_EXIT); // [RULE23]
        end
        `FCSD_OP_ABORT_RST:
        begin
          cyc_a = cmd_addr(bm_r, 2'd0);
          cyc_d = cb(`FCSD_CMD_RESET); // [RULE14]
        end
        `FCSD_OP_PROGRAM:
        begin
          cyc_a = (step_r == 6'd2) ? cmd_addr(bm_r, 2'd0) : addr_r;
          cyc_d = (step_r == 6'd2) ? cb(`FCSD_CMD_PROGRAM) : data_r; // [RULE10]
        end
        `FCSD_OP_CHIP_ERASE, `FCSD_OP_SECT_ERASE:
        begin
          cyc_a = cmd_addr(bm_r, 2'd0);
          case (step_r)
            6'd2: cyc_d = cb(`FCSD_CMD_ERASE_SETUP);
            6'd3: cyc_d = cb(`FCSD_CMD_UNLOCK1);
            6'd4:
            begin
              cyc_a = cmd_addr(bm_r, 2'd1);
              cyc_d = cb(`FCSD_CMD_UNLOCK2);
            end
            default:
            begin
              if (op_r == `FCSD_OP_SECT_ERASE)
              begin
                cyc_a = sect(addr_r);
                cyc_d = cb(`FCSD_CMD_SECTOR_ERASE); // [RULE15]
              end
              else
                cyc_d = cb(`FCSD_CMD_CHIP_ERASE); // [RULE15]
            end
          endcase
        end
        default:
        begin
          // Buffered program
          if (step_r == 6'd2)
          begin
            cyc_a = sect(addr_r);
            cyc_d = cb(`FCSD_CMD_BUF_LOAD); // [RULE11]
          end
          else if (step_r == 6'd3)
          begin
            cyc_a = sect(addr_r);
            cyc_d = {{(DW-6){1'b0}}, cnt_r}; // [RULE11]
          end
          else if (step_r == last_r)
          begin
            cyc_a = sect(addr_r);
            cyc_d = cb(`FCSD_CMD_BUF_CONFIRM); // [RULE24]
          end
          else
          begin
            // Page bits forced from the request address so all loads share one page
            cyc_a = {addr_r[AW-1:4], buf_addr[3:0]}; // [RULE12]
            cyc_d = buf_data;
          end
        end
      endcase
    end
  end
  always @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r <= S_IDLE;
      tmr_r <= 8'h00;
      step_r <= 6'd0;
      last_r <= 6'd0;
      op_r <= `FCSD_OP_READ;
      bm_r <= 1'b0;
      is_read_r <= 1'b0;
      addr_r <= {AW{1'b0}};
      data_r <= {DW{1'b0}};
      cnt_r <= 6'd0;
      bidx_r <= 6'd0;
      fetched_r <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      err_o <= 1'b0;
      rdata_o <= {DW{1'b0}};
      flash_a_o <= {AW{1'b0}};
      flash_dq_o <= {DW{1'b0}};
      flash_dq_oe_o <= 1'b0;
      flash_ce_n_o <= 1'b1;
      flash_we_n_o <= 1'b1;
      flash_oe_n_o <= 1'b1;
    end
    else
    begin
      done_o <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          if (req_i)
          begin
            op_r <= op_i;
            bm_r <= byte_mode_i;
            addr_r <= addr_i;
            data_r <= data_i;
            cnt_r <= count_m1_i;
            bidx_r <= 6'd0;
            busy_o <= 1'b1;
            err_o <= 1'b0;
            // Oversized count would abort in the device; refuse it here [RULE13]
            if (op_i == `FCSD_OP_BUF_PROG && ({1'b0, count_m1_i} >= (byte_mode_i ?
                {1'b0, `FCSD_BUF_MAX_BYTES} : {2'b00, `FCSD_BUF_MAX_WORDS})))
            begin
              err_o <= 1'b1;
              done_o <= 1'b1;
              busy_o <= 1'b0;
            end
            else
            begin
              case (op_i)
                `FCSD_OP_READ, `FCSD_OP_RESET, `FCSD_OP_SUSPEND,
                `FCSD_OP_RESUME, `FCSD_OP_QUERY, `FCSD_OP_ID_READ:
                begin
                  step_r <= 6'd2;
                  last_r <= 6'd2;
                end
                `FCSD_OP_AUTOSEL, `FCSD_OP_SEC_ENTER, `FCSD_OP_ABORT_RST:
                begin
                  step_r <= 6'd0;
                  last_r <= 6'd2;
                end
                `FCSD_OP_PROGRAM, `FCSD_OP_SEC_EXIT:
                begin
                  step_r <= 6'd0;
                  last_r <= 6'd3;
                end
                `FCSD_OP_CHIP_ERASE, `FCSD_OP_SECT_ERASE:
                begin
                  step_r <= 6'd0;
                  last_r <= 6'd5;
                end
                default:
                begin
                  step_r <= 6'd0;
                  last_r <= count_m1_i + 6'd5; // [RULE13]
                end
              endcase
              state_r <= S_FETCH;
            end
          end
        end
        S_FETCH:
        begin
          // One cycle lets the buffer memory present its registered word
          tmr_r <= T_SETUP;
          state_r <= S_SETUP;
          is_read_r <= cyc_read;
          flash_a_o <= cyc_a; // [RULE3]
          flash_dq_o <= cyc_d;
          flash_dq_oe_o <= ~cyc_read;
          flash_ce_n_o <= 1'b0;
        end
        S_SETUP:
        begin
          if (tmr_r <= 8'd1)
          begin
            tmr_r <= T_PULSE;
            state_r <= S_PULSE;
            // Address stable before WE# falls, so the later edge latches it [RULE3]
            flash_we_n_o <= is_read_r;
            flash_oe_n_o <= ~is_read_r;
          end
          else
            tmr_r <= tmr_r - 8'd1;
        end
        S_PULSE:
        begin
          if (tmr_r <= 8'd1)
          begin
            tmr_r <= T_HOLD;
            state_r <= S_HOLD;
            // WE# rises first, CE# later, so data is taken on WE# [RULE4]
            flash_we_n_o <= 1'b1;
            flash_oe_n_o <= 1'b1;
            if (is_read_r)
              rdata_o <= flash_dq_i;
          end
          else
            tmr_r <= tmr_r - 8'd1;
        end
        S_HOLD:
        begin
          if (tmr_r <= 8'd1)
          begin
            flash_ce_n_o <= 1'b1;
            flash_dq_oe_o <= 1'b0;
            state_r <= S_NEXT;
            // Slot chosen two edges before fetch, so the registered word is ready in time
            if (op_r == `FCSD_OP_BUF_PROG && step_r >= 6'd3)
              bidx_r <= step_r - 6'd3;
          end
          else
            tmr_r <= tmr_r - 8'd1;
        end
        default:
        begin
          if (step_r >= last_r)
          begin
            state_r <= S_IDLE;
            busy_o <= 1'b0;
            done_o <= 1'b1; // [RULE21]
          end
          else
          begin
            step_r <= step_r + 6'd1;
            state_r <= S_FETCH;
          end
        end
      endcase
    end
  end
endmodule // fcsd_host
`default_nettype wire

// File: src/fcsd_regs.vh
// Constants for the flash command sequencer: command codes, cycle addresses, timing.
// Assumes a 20 MHz controller clock driving an asynchronous NOR flash bus.
`ifndef FCSD_REGS_VH
`define FCSD_REGS_VH
`define FCSD_CMD_UNLOCK1 8'haa
`define FCSD_CMD_UNLOCK2 8'h55
`define FCSD_CMD_AUTOSEL 8'h90
`define FCSD_CMD_RESET 8'hf0
`define FCSD_CMD_PROGRAM 8'ha0
`define FCSD_CMD_BUF_LOAD 8'h25
`define FCSD_CMD_BUF_CONFIRM 8'h29
`define FCSD_CMD_ERASE_SETUP 8'h80
`define FCSD_CMD_SECTOR_ERASE 8'h30
`define FCSD_CMD_CHIP_ERASE 8'h10
`define FCSD_CMD_SUSPEND 8'hb0
`define FCSD_CMD_RESUME 8'h30
`define FCSD_CMD_QUERY 8'h98
`define FCSD_CMD_SEC_ENTER 8'h88
`define FCSD_CMD_SEC_EXIT 8'h00
`define FCSD_ADDR_CMD_WORD 12'h555
`define FCSD_ADDR_UNL_WORD 12'h2aa
`define FCSD_ADDR_CMD_BYTE 12'haaa
`define FCSD_ADDR_UNL_BYTE 12'h555
`define FCSD_ADDR_QRY_WORD 12'h055
`define FCSD_ADDR_QRY_BYTE 12'h0aa
`define FCSD_OP_READ 4'h0
`define FCSD_OP_RESET 4'h1
`define FCSD_OP_AUTOSEL 4'h2
`define FCSD_OP_PROGRAM 4'h3
`define FCSD_OP_BUF_PROG 4'h4
`define FCSD_OP_ABORT_RST 4'h5
`define FCSD_OP_CHIP_ERASE 4'h6
`define FCSD_OP_SECT_ERASE 4'h7
`define FCSD_OP_SUSPEND 4'h8
`define FCSD_OP_RESUME 4'h9
`define FCSD_OP_QUERY 4'ha
`define FCSD_OP_SEC_ENTER 4'hb
`define FCSD_OP_SEC_EXIT 4'hc
`define FCSD_OP_ID_READ 4'hd
`define FCSD_BUF_MAX_WORDS 5'h10
`define FCSD_BUF_MAX_BYTES 6'h20
`define FCSD_ID_MFR_OFS 8'h00
`define FCSD_ID_DEV1_WORD 8'h01
`define FCSD_ID_DEV2_WORD 8'h0e
`define FCSD_ID_DEV3_WORD 8'h0f
`define FCSD_ID_DEV1_BYTE 8'h02
`define FCSD_ID_DEV2_BYTE 8'h1c
`define FCSD_ID_DEV3_BYTE 8'h1e
`define FCSD_ID_SECLK_WORD 8'h03
`define FCSD_ID_SECLK_BYTE 8'h06
`define FCSD_ID_PROT_WORD 8'h02
`define FCSD_ID_PROT_BYTE 8'h04
`define FCSD_T_SETUP_NS 100
`define FCSD_T_PULSE_NS 100
`define FCSD_T_HOLD_NS 50
`define FCSD_CLK_NS 50
`endif

// File: src/fcsd_buf_mem.v
// Small staging memory for buffered program location/value pairs.
// Assumes single clock; read data comes from a register.
`timescale 1ns/1ps
`default_nettype none
module fcsd_buf_mem #(
  parameter AW = 6,
  parameter DW = 40
) (
  input wire mclk_i,
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire [DW-1:0] wdata_i,
  input wire [AW-1:0] raddr_i,
  output reg [DW-1:0] rdata_o
);
  reg [DW-1:0] mem_r [0:(1<<AW)-1];
  always @(posedge mclk_i)
  begin
    if (we_i)
      mem_r[waddr_i] <= wdata_i;
    rdata_o <= mem_r[raddr_i];
  end
endmodule // fcsd_buf_mem
`default_nettype wire

// File: testbench/fcsd_host_sva.sv
// Checker for the flash command host: strobe shapes and request handling.
// Assumes it is bound to fcsd_host and watches only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module fcsd_host_sva #(
  parameter AW = 22,
  parameter DW = 16
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic byte_mode_i,
  input wire logic [5:0] count_m1_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic err_o,
  input wire logic [AW-1:0] flash_a_o,
  input wire logic [DW-1:0] flash_dq_o,
  input wire logic flash_dq_oe_o,
  input wire logic flash_ce_n_o,
  input wire logic flash_we_n_o,
  input wire logic flash_oe_n_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  idle_quiet_a: assert property (!busy_o && !done_o |-> flash_ce_n_o && flash_we_n_o)
    else $error("Strobe active while idle");
  we_pulse_a: assert property ($fell(flash_we_n_o) |-> !flash_we_n_o [*2] ##1 flash_we_n_o)
    else $error("Write pulse length wrong");
  write_setup_a: assert property ($fell(flash_we_n_o) |-> $past(!flash_ce_n_o) && flash_oe_n_o)
    else $error("Write strobe without chip select");
  write_hold_a: assert property ($rose(flash_we_n_o) |-> !flash_ce_n_o && $stable(flash_dq_o))
    else $error("Data not held at write end");
  pulse_stable_a: assert property (!flash_we_n_o |=> $stable(flash_a_o) && flash_dq_oe_o)
    else $error("Address moved during write");
  read_drive_a: assert property (!flash_oe_n_o |-> !flash_dq_oe_o && flash_we_n_o)
    else $error("Bus driven during read");
  take_req_a: assert property (!busy_o && req_i |-> ##[1:2] (busy_o || done_o))
    else $error("Request not taken");
  done_pulse_a: assert property (done_o |=> !done_o)
    else $error("Done longer than one cycle");
  err_count_a: assert property ($rose(err_o) |-> done_o &&
    $past(count_m1_i) >= ($past(byte_mode_i) ? 6'h20 : 6'h10))
    else $error("Error flag without oversized count");
  done_bound_a: assert property ($rose(busy_o) |-> ##[7:259] done_o)
    else $error("Operation did not finish");
  cover property ($rose(err_o));
  cover property ($fell(flash_we_n_o));
  cover property ($fell(flash_oe_n_o));
endmodule // fcsd_host_sva
`default_nettype wire

// File: testbench/fcsd_flash_model.sv
// Behavioural flash part: logs bus writes, decodes identifier entry, reset, erase suspend.
// Assumes one host on its pins; identifier offsets are the word-mode ones only.
`timescale 1ns/1ps
`default_nettype none
module fcsd_flash_model #(
  parameter logic [15:0] ID_CODE = 16'h2a51 // Arbitrary identifier value
) (
  input wire logic [21:0] a_i,
  input wire logic [15:0] dq_i,
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  output logic [15:0] dq_o
);
  logic [21:0] lat_a;
  logic [21:0] log_a [0:63];
  logic [15:0] log_d [0:63];
  logic [15:0] rd_val;
  logic [15:0] last = 16'h0000;
  logic id_mode = 1'b0; // Power-up in read-array mode
  logic arm = 1'b0;
  logic ers_on = 1'b0;
  logic susp = 1'b0;
  logic [9:0] ers_sec = 10'h000;
  int wr_n = 0;
  int step = 0;
  // A write needs both strobes low with outputs off
  wire logic wsel_n = ce_n_i | we_n_i | ~oe_n_i;
  wire logic rd_en = ~ce_n_i & ~oe_n_i;
  always @(negedge wsel_n) lat_a = a_i;
  always @(posedge wsel_n)
  begin
    log_a[wr_n % 64] = lat_a;
    log_d[wr_n % 64] = dq_i;
    wr_n++;
    // Only data is decoded; unlock addresses do not matter
    if (dq_i[7:0] == 8'hf0)
    begin
      id_mode = 1'b0;
      step = 0;
    end
    else if (step == 2 && dq_i[7:0] == 8'h90)
    begin
      id_mode = 1'b1;
      step = 0;
    end
    else if (step < 2 && dq_i[7:0] == ((step == 0) ? 8'haa : 8'h55))
      step++;
    else
    begin
      if (dq_i[7:0] == 8'h00)
        id_mode = 1'b0;
      else if (step == 2 && dq_i[7:0] == 8'h80)
        arm = 1'b1;
      else if (step == 2 && arm)
      begin
        // A sector erase never completes here, so suspend stays possible
        ers_on = (dq_i[7:0] == 8'h30);
        ers_sec = lat_a[21:12];
        arm = 1'b0;
      end
      else if (step == 0 && dq_i[7:0] == 8'hb0 && ers_on)
        susp = 1'b1;
      else if (step == 0 && dq_i[7:0] == 8'h30 && susp)
        susp = 1'b0;
      step = 0;
    end
  end
  always_comb
    if (susp && a_i[21:12] == ers_sec)
      rd_val = 16'h0080; // Arbitrary status word
    else if (!id_mode)
      rd_val = a_i[15:0] ^ 16'h3c5a;
    else if (a_i[7:0] == 8'h03)
      rd_val = 16'h0018;
    else if (a_i[7:0] == 8'h02)
      rd_val = 16'h0001;
    else
      rd_val = ID_CODE;
  always @(negedge rd_en) last = rd_val;
  // Released bus shows the inverse of the last value, so stale data never passes
  assign dq_o = rd_en ? rd_val : ~last;
endmodule // fcsd_flash_model
`default_nettype wire

// File: testbench/test_fcsd_host.sv
// Self-checking bench for the flash command host against a behavioural flash part.
// Assumes fcsd_host, the flash model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "fcsd_regs.vh"
module test_fcsd_host;
  localparam logic [15:0] ID = 16'h2a51; // Arbitrary identifier value
  localparam logic [21:0] ANY = 22'h3fffff;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req = 1'b0;
  logic bm = 1'b0;
  logic lwe = 1'b0;
  logic [3:0] op = 4'h0;
  logic [5:0] cm = 6'h00;
  logic [5:0] li = 6'h00;
  logic [21:0] ad = 22'h000000;
  logic [21:0] la = 22'h000000;
  logic [15:0] dt = 16'h0000;
  logic [15:0] ld = 16'h0000;
  wire logic busy, done, err, dq_oe, ce_n, we_n, oe_n;
  wire logic [15:0] rdata, dq_h, dq_f;
  wire logic [21:0] fa;
  wire logic [15:0] dq_w = dq_oe ? dq_h : dq_f;
  int err_count = 0;
  int checks = 0;
  int base = 0;
  logic [37:0] exq [$];
  always #25 mclk_i = ~mclk_i;
  fcsd_host fcsd_host_inst (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req), .op_i(op),
    .byte_mode_i(bm), .addr_i(ad), .data_i(dt), .count_m1_i(cm), .load_we_i(lwe),
    .load_idx_i(li), .load_addr_i(la), .load_data_i(ld), .busy_o(busy), .done_o(done),
    .err_o(err), .rdata_o(rdata), .flash_a_o(fa), .flash_dq_o(dq_h), .flash_dq_oe_o(dq_oe),
    .flash_dq_i(dq_w), .flash_ce_n_o(ce_n), .flash_we_n_o(we_n), .flash_oe_n_o(oe_n));
  fcsd_flash_model #(.ID_CODE(ID)) fcsd_flash_model_inst (.a_i(fa), .dq_i(dq_w),
    .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .dq_o(dq_f));
  task automatic cmp(input logic [37:0] got, input logic [37:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic ex(input logic [21:0] a, input logic [15:0] d);
    exq.push_back({a, d});
  endtask
  task automatic unl(input logic b);
    ex(b ? 22'h000aaa : 22'h000555, 16'h00aa);
    ex(b ? 22'h000555 : 22'h0002aa, 16'h0055);
  endtask
  task automatic run(input logic [3:0] o, input logic [21:0] a,
    input logic [15:0] d = 16'h0000, input logic [5:0] c = 6'h00);
    int n;
    n = 0;
    @(negedge mclk_i);
    base = fcsd_flash_model_inst.wr_n;
    op = o;
    ad = a;
    dt = d;
    cm = c;
    req = 1'b1;
    @(negedge mclk_i);
    req = 1'b0;
    while (done !== 1'b1 && n < 400)
    begin
      @(negedge mclk_i);
      n++;
    end
    if (n == 400)
      cmp(38'h0, 38'h1);
  endtask
  // Bus writes seen by the flash part since the last request, in order
  task automatic chk_log;
    logic [21:0] a;
    cmp(38'(fcsd_flash_model_inst.wr_n - base), 38'(exq.size()));
    foreach (exq[i])
    begin
      a = fcsd_flash_model_inst.log_a[(base + i) % 64];
      cmp({((exq[i][37:16] == ANY) ? ANY : a), fcsd_flash_model_inst.log_d[(base + i) % 64]},
        exq[i]);
    end
    exq.delete();
  endtask
  task automatic t_read;
    run(`FCSD_OP_READ, 22'h001234);
    cmp(38'(rdata), 38'(16'h1234 ^ 16'h3c5a));
    chk_log;
  endtask
  task automatic t_ident;
    run(`FCSD_OP_AUTOSEL, 22'h000000);
    unl(1'b0);
    ex(22'h000555, 16'h0090);
    chk_log;
    run(`FCSD_OP_ID_READ, 22'h000001);
    cmp(38'(rdata), 38'(ID));
    run(`FCSD_OP_ID_READ, 22'h000003);
    cmp(38'(rdata), 38'h18);
    run(`FCSD_OP_ID_READ, 22'h0a5002);
    cmp(38'(rdata), 38'h1);
    run(`FCSD_OP_QUERY, 22'h000000);
    ex(22'h000055, 16'h0098);
    chk_log;
    run(`FCSD_OP_RESET, 22'h000000);
    ex(ANY, 16'h00f0);
    chk_log;
    run(`FCSD_OP_READ, 22'h000003);
    cmp(38'(rdata), 38'(16'h0003 ^ 16'h3c5a));
  endtask
  task automatic t_prog;
    for (int b = 0; b < 2; b++)
    begin
      bm = b[0];
      run(`FCSD_OP_PROGRAM, 22'h012345, 16'hbeef);
      unl(b[0]);
      ex(b[0] ? 22'h000aaa : 22'h000555, 16'h00a0);
      ex(22'h012345, 16'hbeef);
      chk_log;
    end
    bm = 1'b0;
  endtask
  task automatic t_erase;
    run(`FCSD_OP_SECT_ERASE, 22'h2b7ff);
    unl(1'b0);
    ex(22'h000555, 16'h0080);
    unl(1'b0);
    ex(22'h2b000, 16'h0030);
    chk_log;
    run(`FCSD_OP_SUSPEND, 22'h000000);
    ex(ANY, 16'h00b0);
    chk_log;
    run(`FCSD_OP_READ, 22'h02b123);
    cmp(38'(rdata), 38'h80);
    run(`FCSD_OP_READ, 22'h001234);
    cmp(38'(rdata), 38'(16'h1234 ^ 16'h3c5a));
    run(`FCSD_OP_RESUME, 22'h000000);
    ex(ANY, 16'h0030);
    chk_log;
    run(`FCSD_OP_CHIP_ERASE, 22'h000000);
    unl(1'b0);
    ex(22'h000555, 16'h0080);
    unl(1'b0);
    ex(22'h000555, 16'h0010);
    chk_log;
  endtask
  task automatic t_sec;
    run(`FCSD_OP_SEC_ENTER, 22'h000000);
    unl(1'b0);
    ex(22'h000555, 16'h0088);
    chk_log;
    run(`FCSD_OP_SEC_EXIT, 22'h000000);
    unl(1'b0);
    ex(22'h000555, 16'h0090);
    ex(ANY, 16'h0000);
    chk_log;
    run(`FCSD_OP_ABORT_RST, 22'h000000);
    unl(1'b0);
    ex(22'h000555, 16'h00f0);
    chk_log;
  endtask
  // Full buffer: the longest legal word-mode sequence, then one count too many
  task automatic t_buf;
    for (int i = 0; i < 16; i++)
    begin
      @(negedge mclk_i);
      lwe = 1'b1;
      li = 6'(i);
      la = 22'(15 - i);
      ld = 16'(16'h7100 + i);
    end
    @(negedge mclk_i);
    lwe = 1'b0;
    run(`FCSD_OP_BUF_PROG, 22'h2b350, 16'h0000, 6'h0f);
    unl(1'b0);
    ex(22'h2b000, 16'h0025);
    ex(22'h2b000, 16'h000f);
    for (int i = 0; i < 16; i++)
      ex(22'h2b350 | 22'(15 - i), 16'(16'h7100 + i));
    ex(22'h2b000, 16'h0029);
    chk_log;
    cmp(38'(err), 38'h0);
    run(`FCSD_OP_BUF_PROG, 22'h2b350, 16'h0000, 6'h10);
    cmp(38'(err), 38'h1);
    chk_log;
  endtask
  // Reset before the first write pulse: pins go idle and no write reaches the part
  task automatic t_rst;
    @(negedge mclk_i);
    base = fcsd_flash_model_inst.wr_n;
    op = `FCSD_OP_SECT_ERASE;
    ad = 22'h02b000;
    req = 1'b1;
    @(negedge mclk_i);
    req = 1'b0;
    repeat (2) @(negedge mclk_i);
    rst_i = 1'b1;
    @(negedge mclk_i);
    cmp(38'({busy, done, err, ce_n, we_n, oe_n, dq_oe}), 38'h0e);
    cmp(38'(rdata), 38'h0);
    rst_i = 1'b0;
    chk_log;
    run(`FCSD_OP_READ, 22'h000055);
    cmp(38'(rdata), 38'(16'h0055 ^ 16'h3c5a));
  endtask
  task automatic summarize;
    if (err_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i = 1'b0;
    t_read;
    t_ident;
    t_prog;
    t_erase;
    t_sec;
    t_buf;
    t_rst;
    summarize;
  end
  // About 550 cycles are needed; cut off well beyond that
  initial
  begin
    #1000000;
    err_count++;
    summarize;
  end
endmodule // test_fcsd_host
bind fcsd_host fcsd_host_sva #(.AW(AW), .DW(DW)) fcsd_host_sva_inst (.mclk_i(mclk_i),
  .rst_i(rst_i), .req_i(req_i), .byte_mode_i(byte_mode_i), .count_m1_i(count_m1_i),
  .busy_o(busy_o), .done_o(done_o), .err_o(err_o), .flash_a_o(flash_a_o),
  .flash_dq_o(flash_dq_o), .flash_dq_oe_o(flash_dq_oe_o), .flash_ce_n_o(flash_ce_n_o),
  .flash_we_n_o(flash_we_n_o), .flash_oe_n_o(flash_oe_n_o));
`default_nettype wire
